// ===== drive_status_pkg.sv
// package for the drive status word and serial slave settings block
// assumes a single clk_sys domain; all inputs from the drive core are sampled here
package drive_status_pkg;
  // ****************************************
  // status word bit positions
  // ****************************************
  localparam int unsigned BIT_READY_TO_SWITCH_ON = 0;
  localparam int unsigned BIT_READY = 1;
  localparam int unsigned BIT_OP_ENABLED = 2;
  localparam int unsigned BIT_FAULT = 3;
  localparam int unsigned BIT_NO_COAST_STOP = 4;
  localparam int unsigned BIT_NO_QUICK_STOP = 5;
  localparam int unsigned BIT_SWITCH_ON_INHIBIT = 6;
  localparam int unsigned BIT_ALARM = 7;
  localparam int unsigned BIT_SPEED_IN_TOL = 8;
  localparam int unsigned BIT_MASTER_REQ = 9;
  localparam int unsigned BIT_SPEED_REACHED = 10;
  localparam int unsigned BIT_TORQUE_OK = 11;
  localparam int unsigned BIT_RESERVED = 12;
  localparam int unsigned BIT_MOTOR_TEMP_OK = 13;
  localparam int unsigned BIT_CLOCKWISE = 14;
  localparam int unsigned BIT_CONV_TEMP_OK = 15;
  localparam logic RESERVED_VALUE = 1'b0;
  // control word bit positions used here
  localparam int unsigned CW_ON = 0;
  localparam int unsigned CW_ENABLE_OP = 3;
  localparam int unsigned CW_FAULT_ACK = 7;

  // ****************************************
  // settings, factory values and limits
  // ****************************************
  localparam logic [3:0] BAUD_CODE_MIN = 4'h4;
  localparam logic [3:0] BAUD_CODE_MAX = 4'hd;
  localparam logic [3:0] BAUD_CODE_RESET = 4'h8;
  localparam logic [4:0] NODE_ADDR_MAX = 5'h1e;
  localparam logic [4:0] NODE_ADDR_RESET = 5'h00;
  localparam logic [3:0] PD_WORDS_RESET = 4'h2;
  localparam logic [6:0] PARAM_LEN_0 = 7'h00;
  localparam logic [6:0] PARAM_LEN_3 = 7'h03;
  localparam logic [6:0] PARAM_LEN_4 = 7'h04;
  localparam logic [6:0] PARAM_LEN_VAR = 7'h7f;
  localparam logic [15:0] TELEGRAM_FAIL_MS_RESET = 16'h03e8;
  localparam logic [15:0] CHAR_DELAY_MS_RESET = 16'h0000;
  localparam logic [15:0] DEAD_TIME_MS_RESET = 16'h0000;
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_ODD = 2'h1;
  localparam logic [1:0] PARITY_EVEN = 2'h2;
  localparam logic [3:0] PROTOCOL_RESET = 4'h1;
  localparam logic [3:0] PROTOCOL_DRIVE_SLAVE = 4'h1;
  localparam logic [15:0] MONITOR_RESET = 16'h0064;
  // statistics indices for the receive error counters
  localparam int unsigned STAT_PARITY = 4;
  localparam int unsigned STAT_START = 5;
  localparam int unsigned STAT_CHECKSUM = 6;
  localparam int unsigned STAT_LENGTH = 7;
  localparam int unsigned STAT_DEPTH = 8;

  // baud rate table indexed by code, zero for unused codes
  localparam logic [17:0] BAUD_TABLE [16] = '{
    18'd0, 18'd0, 18'd0, 18'd0, 18'd2400, 18'd4800, 18'd9600, 18'd19200,
    18'd38400, 18'd57600, 18'd76800, 18'd93750, 18'd115200, 18'd187500,
    18'd0, 18'd0};

  // drive core conditions feeding the status word
  typedef struct packed {
    logic supply_ok;
    logic init_done;
    logic pulses_locked;
    logic fault_event;
    logic coast_stop_active;
    logic quick_stop_active;
    logic alarm;
    logic speed_in_tol;
    logic master_req;
    logic speed_reached;
    logic torque_below;
    logic motor_overtemp;
    logic conv_overload;
    logic speed_positive;
  } drive_cond_t;

  // receive error strobes from the telegram framer
  typedef struct packed {
    logic parity_err;
    logic start_err;
    logic checksum_err;
    logic length_err;
  } rx_err_t;

  // active serial slave configuration
  typedef struct packed {
    logic [3:0] baud_code;
    logic [17:0] baud_rate;
    logic [4:0] node_addr;
    logic [3:0] pd_words;
    logic [6:0] param_len;
    logic [15:0] fail_time_ms;
    logic [15:0] char_delay_ms;
    logic [15:0] dead_time_ms;
    logic [1:0] parity;
    logic protocol_on;
    logic monitor_on;
  } link_cfg_t;

  // settings write port
  typedef enum logic [3:0] {
    SET_BAUD, SET_ADDR, SET_PD, SET_PARAM, SET_FAIL, SET_CHAR, SET_DEAD,
    SET_PARITY, SET_PROTOCOL, SET_MONITOR
  } setting_sel_t;
endpackage : drive_status_pkg

// ===== drive_status_word_serial_slave.sv
// status word assembly and serial slave settings for a drive converter
// assumes drive core inputs come from logic on clk_sys; settings are written
// through a simple strobe port by the converter's own parameter handler
// assumes resetn stands for a power cycle; only the stored node address
// outlives it, so a saved address can take effect at the next start
// assumes the framer reads link_cfg as levels and never through a strobe
// Operation
// - bit0: supply, init done, pulses locked
// - bit1: on command and no fault
// - bit2: operation enabled, follows control bit3
// - bit3: fault held until acknowledge bit7
// - bit4 no coast stop, bit5 no quick stop
// - bit6: switch-on inhibit until the off command
// - bit7: alarm, no acknowledge needed
// - bit8: speed deviation inside tolerance
// - bit9: converter requests master control
// - bit10: speed at or above comparison
// - bit11: torque below comparison value
// - bits13,15 active-low thermal alarms
// - bit14: positive speed is clockwise
// - slave only, answers master requests
// - baud codes 4..13, default 8
// - address 0..30, active after power cycle
// - process word count, default 2
// - parameter length 0,3,4,127; default 127
// - failure, character delay, dead times
// - separate error counters at indices 4..7
// - parity none/odd/even, default even
// - protocol 1 selects; monitor 0 disables
module drive_status_word_serial_slave
  import drive_status_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] drive_control_word,
  input wire drive_cond_t cond,
  input wire rx_err_t rx_err,
  input wire logic set_we,
  input wire setting_sel_t set_sel,
  input wire logic [15:0] set_data,
  input wire logic [2:0] stat_index,
  output logic [15:0] stat_count,
  output logic [15:0] drive_status_word,
  output link_cfg_t link_cfg,
  output logic reply_allowed
);
  // ****************************************
  // drive state tracking
  // ****************************************
  // the control word is a level from the framer on this same clock, so it
  // needs no synchroniser; edges are found against last cycle's copy
  logic fault_hold; // latched fault, cleared by acknowledge edge
  logic inhibit; // switch-on inhibit
  logic ack_prev; // last acknowledge bit, for the rising edge
  logic on_prev; // last on bit, for the rising edge
  logic ack_rise;
  logic on_rise;
  logic on_cmd;
  logic ready;

  // both history bits reset to the idle level (low) of their control bits,
  // so no false edge shows up on the first cycle after reset
  assign on_cmd = drive_control_word[CW_ON];
  assign ack_rise = drive_control_word[CW_FAULT_ACK] & ~ack_prev;
  assign on_rise = on_cmd & ~on_prev;

  // edge history of control bits
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_prev <= 1'b0;
      on_prev <= 1'b0;
    end else begin
      ack_prev <= drive_control_word[CW_FAULT_ACK];
      on_prev <= on_cmd;
    end
  end

  // ****************************************
  // latched drive states
  // ****************************************
  // fault latch: a new fault wins over a simultaneous acknowledge
  // the acknowledge is edge triggered: holding bit 7 high does not mask a
  // later fault, the master has to drop the bit and raise it again
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_hold <= 1'b0;
    end else if (cond.fault_event) begin
      fault_hold <= 1'b1;
    end else if (ack_rise) begin
      fault_hold <= 1'b0;
    end
  end

  // inhibit: set at power-up, by a stop or while a fault is held, so it is still set after acknowledging with on set
  // it lifts only once the master has dropped the on bit, which is the
  // off command that must come before a new start
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      inhibit <= 1'b1;
    end else if (cond.coast_stop_active || cond.quick_stop_active || fault_hold) begin
      inhibit <= 1'b1;
    end else if (!on_cmd) begin
      inhibit <= 1'b0; // off command releases; a new on edge then starts
    end
  end

  // ready needs an on edge after the inhibit has lifted
  // a level check of the on bit would let a word still carrying on from
  // before a fault restart the motor without a fresh command
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ready <= 1'b0;
    end else if (!on_cmd || fault_hold || inhibit || cond.coast_stop_active
                 || cond.quick_stop_active) begin
      ready <= 1'b0;
    end else if (on_rise) begin
      ready <= 1'b1;
    end
  end

  // ****************************************
  // status word register
  // ****************************************
  // registered so that a reply always carries one consistent snapshot
  // the price is one cycle of latency on every bit, two on latched ones
  // thermal bits are inverted here so that zero means alarm in the word
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive_status_word <= 16'h0000;
    end else begin
      // bit 0 drops while inhibited, so the master never reads ready for
      // switching on together with switch-on inhibit
      drive_status_word[BIT_READY_TO_SWITCH_ON] <= cond.supply_ok & cond.init_done
                                                  & cond.pulses_locked & ~inhibit;
      drive_status_word[BIT_READY] <= ready & ~fault_hold;
      drive_status_word[BIT_OP_ENABLED] <= ready & ~fault_hold
                                          & drive_control_word[CW_ENABLE_OP];
      drive_status_word[BIT_FAULT] <= fault_hold;
      drive_status_word[BIT_NO_COAST_STOP] <= ~cond.coast_stop_active;
      drive_status_word[BIT_NO_QUICK_STOP] <= ~cond.quick_stop_active;
      drive_status_word[BIT_SWITCH_ON_INHIBIT] <= inhibit;
      drive_status_word[BIT_ALARM] <= cond.alarm;
      drive_status_word[BIT_SPEED_IN_TOL] <= cond.speed_in_tol;
      drive_status_word[BIT_MASTER_REQ] <= cond.master_req;
      drive_status_word[BIT_SPEED_REACHED] <= cond.speed_reached;
      drive_status_word[BIT_TORQUE_OK] <= cond.torque_below;
      drive_status_word[BIT_RESERVED] <= RESERVED_VALUE;
      drive_status_word[BIT_MOTOR_TEMP_OK] <= ~cond.motor_overtemp;
      drive_status_word[BIT_CLOCKWISE] <= cond.speed_positive;
      drive_status_word[BIT_CONV_TEMP_OK] <= ~cond.conv_overload;
    end
  end

  // ****************************************
  // settings
  // ****************************************
  // working copies; all but the address act on the cycle after a write
  logic [3:0] baud_code;
  logic [4:0] addr_stored = NODE_ADDR_RESET; // power-on value, kept across resetn
  logic [4:0] addr_active;
  logic addr_loaded; // active address captured after reset release
  logic [3:0] pd_words;
  logic [6:0] param_len;
  logic [15:0] fail_ms;
  logic [15:0] char_ms;
  logic [15:0] dead_ms;
  logic [1:0] parity;
  logic [3:0] protocol;
  logic [15:0] monitor;

  // writes outside the legal ranges are ignored and the old value stays
  // timing and monitor words take any value; their meaning belongs to the
  // framer, which owns the millisecond timers
  // a refused write gives no error: the handler must read back to be sure
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      baud_code <= BAUD_CODE_RESET;
      pd_words <= PD_WORDS_RESET;
      param_len <= PARAM_LEN_VAR;
      fail_ms <= TELEGRAM_FAIL_MS_RESET;
      char_ms <= CHAR_DELAY_MS_RESET;
      dead_ms <= DEAD_TIME_MS_RESET;
      parity <= PARITY_EVEN;
      protocol <= PROTOCOL_RESET;
      monitor <= MONITOR_RESET;
    end else if (set_we) begin
      case (set_sel)
        SET_BAUD: if (set_data[3:0] >= BAUD_CODE_MIN && set_data[3:0] <= BAUD_CODE_MAX
                      && set_data[15:4] == 12'h000) begin
          baud_code <= set_data[3:0];
        end
        // the address is written by its own process further down
        SET_PD: if (set_data[15:4] == 12'h000) begin
          pd_words <= set_data[3:0];
        end
        // 127 asks for a variable length parameter channel
        SET_PARAM: if (set_data[6:0] == PARAM_LEN_0 || set_data[6:0] == PARAM_LEN_3
                       || set_data[6:0] == PARAM_LEN_4 || set_data[6:0] == PARAM_LEN_VAR) begin
          param_len <= set_data[6:0];
        end
        SET_FAIL: fail_ms <= set_data;
        SET_CHAR: char_ms <= set_data;
        SET_DEAD: dead_ms <= set_data;
        // code 3 means nothing and is refused
        SET_PARITY: if (set_data[1:0] != 2'h3 && set_data[15:2] == 14'h0000) begin
          parity <= set_data[1:0];
        end
        SET_PROTOCOL: protocol <= set_data[3:0];
        SET_MONITOR: monitor <= set_data;
        default: ;
      endcase
    end
  end

  // ****************************************
  // node address
  // ****************************************
  // stored copy has no reset: resetn stands for a power cycle, and a saved
  // address must outlive it to take effect at the next start
  always_ff @(posedge clk_sys) begin
    if (set_we && set_sel == SET_ADDR && set_data[4:0] <= NODE_ADDR_MAX
        && set_data[15:5] == 11'h000) begin
      addr_stored <= set_data[4:0];
    end
  end

  // address taken once after reset release; reset stands in for power cycling
  // a write while running only moves the stored copy, so the framer never
  // sees its own address change in the middle of a telegram
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      addr_active <= NODE_ADDR_RESET;
      addr_loaded <= 1'b0;
    end else if (!addr_loaded) begin
      addr_active <= addr_stored;
      addr_loaded <= 1'b1;
    end
  end

  // configuration seen by the telegram framer
  // refused baud codes never reach the table, so the rate is never zero
  always_comb begin
    link_cfg.baud_code = baud_code;
    link_cfg.baud_rate = BAUD_TABLE[baud_code];
    link_cfg.node_addr = addr_active;
    link_cfg.pd_words = pd_words;
    link_cfg.param_len = param_len;
    link_cfg.fail_time_ms = fail_ms;
    link_cfg.char_delay_ms = char_ms;
    link_cfg.dead_time_ms = dead_ms;
    link_cfg.parity = parity;
    link_cfg.protocol_on = (protocol == PROTOCOL_DRIVE_SLAVE);
    link_cfg.monitor_on = (monitor != 16'h0000);
  end

  // slave never talks on its own; framer may reply only to a master request
  // with another protocol selected the framer keeps off the line
  // combinational on purpose: a protocol change acts on the next telegram
  assign reply_allowed = link_cfg.protocol_on;

  // ****************************************
  // receive error statistics
  // ****************************************
  // one word per index, so the read is a plain array select
  logic [15:0] stats [STAT_DEPTH]; // read-only, indices below 4 stay zero

  // saturating counters, one per error class
  // saturation keeps a long error burst from wrapping to a small count
  // that would look like a healthy line
  // strobes of different classes may fall in one cycle and all count
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < STAT_DEPTH; i++) begin
        stats[i] <= 16'h0000;
      end
    end else begin
      if (rx_err.parity_err && stats[STAT_PARITY] != 16'hffff) begin
        stats[STAT_PARITY] <= stats[STAT_PARITY] + 16'h0001;
      end
      if (rx_err.start_err && stats[STAT_START] != 16'hffff) begin
        stats[STAT_START] <= stats[STAT_START] + 16'h0001;
      end
      if (rx_err.checksum_err && stats[STAT_CHECKSUM] != 16'hffff) begin
        stats[STAT_CHECKSUM] <= stats[STAT_CHECKSUM] + 16'h0001;
      end
      if (rx_err.length_err && stats[STAT_LENGTH] != 16'hffff) begin
        stats[STAT_LENGTH] <= stats[STAT_LENGTH] + 16'h0001;
      end
    end
  end

  // ****************************************
  // statistics read port
  // ****************************************
  // registered read of the selected counter
  // one cycle late, but the reader never sees a counter mid-update
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stat_count <= 16'h0000;
    end else begin
      stat_count <= stats[stat_index];
    end
  end
endmodule : drive_status_word_serial_slave

// ===== drive_status_monitor.sv
// checker for the drive status word and serial slave settings block
// sees only the top module's ports; attached by the bind at the foot
module drive_status_monitor
  import drive_status_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] drive_control_word,
  input wire drive_cond_t cond,
  input wire rx_err_t rx_err,
  input wire logic set_we,
  input wire setting_sel_t set_sel,
  input wire logic [15:0] set_data,
  input wire logic [2:0] stat_index,
  input wire logic [15:0] stat_count,
  input wire logic [15:0] drive_status_word,
  input wire link_cfg_t link_cfg,
  input wire logic reply_allowed
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // timing relations at the ports
  // ****************************************
  // one domain; the past guard skips the first edge after reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_ALARM: assert property ($past(resetn) |-> drive_status_word[7] == $past(cond.alarm))
    else $error("alarm bit does not follow alarm input");
  AST_NO_STOPS: assert property ($past(resetn) |-> drive_status_word[5:4] ==
    ~{$past(cond.quick_stop_active), $past(cond.coast_stop_active)})
    else $error("stop bits wrong");
  AST_THERMAL: assert property ($past(resetn) |-> drive_status_word[13] ==
    !$past(cond.motor_overtemp) && drive_status_word[15] == !$past(cond.conv_overload))
    else $error("thermal alarm bits wrong");
  AST_DIRECTION: assert property ($past(resetn) |-> drive_status_word[14] ==
    $past(cond.speed_positive))
    else $error("direction bit wrong");
  AST_RESERVED: assert property (drive_status_word[12] == RESERVED_VALUE)
    else $error("reserved bit moved");
  AST_FAULT: assert property (cond.fault_event |-> ##2 drive_status_word[3])
    else $error("fault not shown two cycles after event");
  AST_READY_NO_FAULT: assert property (drive_status_word[3] |-> !drive_status_word[1])
    else $error("ready while fault shown");
  AST_ENABLE: assert property ($past(resetn) && !$past(drive_control_word[3]) |->
    !drive_status_word[2])
    else $error("operation enabled without enable bit");
  AST_BAUD_WRITE: assert property (set_we && set_sel == SET_BAUD &&
    set_data inside {[4:13]} |=> link_cfg.baud_code == $past(set_data[3:0]))
    else $error("baud code write not taken");
  // two-deep guard: the address is loaded on the first edge after release
  AST_ADDR_HELD: assert property ($past(resetn, 2) |-> $stable(link_cfg.node_addr))
    else $error("address changed without reset");
  AST_STAT_LOW: assert property (stat_index < 3'h4 |=> stat_count == 16'h0000)
    else $error("unused statistics index not zero");
  AST_REPLY: assert property (set_we && set_sel == SET_PROTOCOL |=>
    reply_allowed == ($past(set_data[3:0]) == PROTOCOL_DRIVE_SLAVE))
    else $error("reply enable does not follow protocol select");
  // main scenarios seen at least once
  COV_FAULT: cover property (cond.fault_event ##2 drive_status_word[3]);
  COV_BAUD: cover property (set_we && set_sel == SET_BAUD);
  COV_START_ERR: cover property (rx_err.start_err ##1 rx_err.start_err);
  COV_ADDR_MOVED: cover property (link_cfg.node_addr != 5'h00);
endmodule : drive_status_monitor

bind drive_status_word_serial_slave drive_status_monitor mon (.clk_sys(clk_sys),
  .resetn(resetn), .drive_control_word(drive_control_word), .cond(cond), .rx_err(rx_err),
  .set_we(set_we), .set_sel(set_sel), .set_data(set_data), .stat_index(stat_index),
  .stat_count(stat_count), .drive_status_word(drive_status_word), .link_cfg(link_cfg),
  .reply_allowed(reply_allowed));

// ===== fieldbus_master_model.sv
// model of the single fieldbus master that sends control words
// assumes the bench calls send_cw; words change at the falling edge
module fieldbus_master_model (
  input wire logic clk_sys,
  output logic [15:0] drive_control_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle master: all control bits low until it speaks
  initial drive_control_word = 16'h0000;
  // only this one master ever changes the word, slaves never do
  task automatic send_cw(input logic [15:0] w);
    @(negedge clk_sys);
    drive_control_word = w;
  endtask : send_cw
endmodule : fieldbus_master_model

// ===== drive_status_word_serial_slave_test.sv
// testbench for the drive status word and serial slave settings block
// assumes a 20 MHz clk_sys; all inputs change at the falling edge
module drive_status_word_serial_slave_test;
  import drive_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  wire logic [15:0] drive_control_word;
  drive_cond_t cond = '0;
  rx_err_t rx_err = '0;
  logic set_we = 1'b0;
  setting_sel_t set_sel = SET_BAUD;
  logic [15:0] set_data = 16'h0000;
  logic [2:0] stat_index = 3'h0;
  logic [15:0] stat_count;
  logic [15:0] drive_status_word;
  link_cfg_t link_cfg;
  logic reply_allowed;
  int miscompares = 0;
  int check_count = 0;
  int unsigned rates [10] = '{2400, 4800, 9600, 19200, 38400, 57600, 76800, 93750,
    115200, 187500};
  int unsigned plen [4] = '{0, 3, 4, 127};
  always #25 clk_sys = ~clk_sys;
  fieldbus_master_model master (.clk_sys(clk_sys), .drive_control_word(drive_control_word));
  drive_status_word_serial_slave dut (.clk_sys(clk_sys), .resetn(resetn),
    .drive_control_word(drive_control_word), .cond(cond), .rx_err(rx_err), .set_we(set_we),
    .set_sel(set_sel), .set_data(set_data), .stat_index(stat_index), .stat_count(stat_count),
    .drive_status_word(drive_status_word), .link_cfg(link_cfg), .reply_allowed(reply_allowed));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step
  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk
  // one strobe cycle, then a low cycle, so back to back calls never collide
  task automatic wr(input setting_sel_t s, input logic [15:0] d);
    @(negedge clk_sys);
    set_we = 1'b1;
    set_sel = s;
    set_data = d;
    @(negedge clk_sys);
    set_we = 1'b0;
  endtask : wr
  task automatic do_reset;
    resetn = 1'b0;
    step(5);
    resetn = 1'b1;
  endtask : do_reset
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // a hang cuts the run short well past the expected 130 or so cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    logic [15:0] e;
    do_reset();
    step(1);
    chk(18'(link_cfg.baud_code), 18'h8, "baud default");
    chk(link_cfg.baud_rate, 18'd38400, "rate default");
    chk(18'(link_cfg.pd_words), 18'h2, "pd default");
    chk(18'(link_cfg.param_len), 18'h7f, "param default");
    chk(18'(link_cfg.fail_time_ms), 18'd1000, "fail default");
    chk(18'(link_cfg.char_delay_ms | link_cfg.dead_time_ms), 18'h0, "delays");
    chk(18'(link_cfg.parity), 18'h2, "parity default");
    chk(18'({reply_allowed, link_cfg.monitor_on}), 18'h3, "proto default");
    chk(18'(drive_status_word[6]), 18'h1, "inhibit after reset");
    $display("test defaults done");
    // one condition at a time; latched bits are masked out here
    for (int i = 0; i < 14; i++) begin
      if (i != 10) begin
        cond = drive_cond_t'(14'h0001 << i);
        step(1);
        e = {!cond.conv_overload, cond.speed_positive, !cond.motor_overtemp, 1'b0,
          cond.torque_below, cond.speed_reached, cond.master_req, cond.speed_in_tol,
          cond.alarm, 1'b0, !cond.quick_stop_active, !cond.coast_stop_active, 4'h0};
        chk(18'(drive_status_word & 16'hffb0), 18'(e), "level bits");
      end
    end
    $display("test level bits done");
    cond = '0;
    cond.supply_ok = 1'b1;
    cond.init_done = 1'b1;
    cond.pulses_locked = 1'b1;
    step(3);
    chk(18'(drive_status_word[6:0] & 7'h41), 18'h01, "ready to switch on");
    master.send_cw(16'h0001);
    step(3);
    chk(18'(drive_status_word[2:1]), 18'h1, "ready without enable");
    master.send_cw(16'h0009);
    step(2);
    chk(18'(drive_status_word[2:1]), 18'h3, "operation enabled");
    cond.fault_event = 1'b1;
    step(1);
    cond.fault_event = 1'b0;
    step(5);
    chk(18'({drive_status_word[3], drive_status_word[1]}), 18'h2, "fault held");
    master.send_cw(16'h0089);
    step(3);
    chk(18'({drive_status_word[3], drive_status_word[6]}), 18'h1, "ack with on");
    master.send_cw(16'h0000);
    step(3);
    chk(18'(drive_status_word[6]), 18'h0, "inhibit left after off");
    $display("test state bits done");
    wr(SET_ADDR, 16'h001e);
    wr(SET_ADDR, 16'h001f);
    chk(18'(link_cfg.node_addr), 18'h0, "address not yet active");
    do_reset();
    step(1);
    chk(18'(link_cfg.node_addr), 18'h1e, "address after reset");
    for (int i = 4; i < 14; i++) begin
      wr(SET_BAUD, 16'(i));
      chk(link_cfg.baud_rate, 18'(rates[i-4]), "baud rate");
    end
    wr(SET_BAUD, 16'h0003);
    wr(SET_BAUD, 16'h000e);
    chk(18'(link_cfg.baud_code), 18'hd, "baud refused");
    foreach (plen[k]) begin
      wr(SET_PARAM, 16'(plen[k]));
      chk(18'(link_cfg.param_len), 18'(plen[k]), "param length");
    end
    wr(SET_PARAM, 16'h0005);
    chk(18'(link_cfg.param_len), 18'h7f, "param refused");
    for (int i = 0; i < 4; i++) begin
      wr(SET_PARITY, 16'(i));
      chk(18'(link_cfg.parity), 18'((i == 3) ? 2 : i), "parity");
    end
    wr(SET_PD, 16'h0005);
    wr(SET_PD, 16'h0010);
    wr(SET_FAIL, 16'h0001);
    wr(SET_CHAR, 16'h0002);
    wr(SET_DEAD, 16'h0003);
    chk(18'(link_cfg.pd_words), 18'h5, "pd words");
    chk(18'(link_cfg.fail_time_ms + link_cfg.char_delay_ms * 16'h0010 +
      link_cfg.dead_time_ms * 16'h0100), 18'h321, "times");
    wr(SET_PROTOCOL, 16'h0000);
    wr(SET_MONITOR, 16'h0000);
    chk(18'({reply_allowed, link_cfg.monitor_on}), 18'h0, "protocol and monitor off");
    wr(SET_PROTOCOL, 16'h0001);
    chk(18'(reply_allowed), 18'h1, "protocol on");
    $display("test settings done");
    // back to back strobes: error k is pulsed k+1 cycles in a row
    for (int k = 0; k < 4; k++) begin
      rx_err = rx_err_t'(4'h8 >> k);
      step(k + 1);
    end
    rx_err = '0;
    for (int k = 0; k < 5; k++) begin
      stat_index = (k == 4) ? 3'h0 : 3'(k + 4);
      step(2);
      chk(18'(stat_count), 18'((k == 4) ? 0 : k + 1), "error count");
    end
    $display("test statistics done");
    end_sim();
  end
endmodule : drive_status_word_serial_slave_test
